// file: common/dac_ctl_map.svh
// Register map, field positions, reset values and trigger codes of the converter channel.
// Assumes inclusion by bare name from the package only; the design module does not include it.
`ifndef DAC_CTL_MAP_SVH
`define DAC_CTL_MAP_SVH

// Byte offsets on the register bus (32-bit words, 16-bit data in low bits).
`define OFS_CONTROL        4'h0
`define OFS_CODE           4'h4
`define OFS_BUFFER         4'h8
`define OFS_STATUS         4'hC

// Control register fields.
`define CTL_ENABLE_BIT     15
`define CTL_IDLE_STOP_BIT  13
`define CTL_SLEEP_RUN_BIT  12
`define CTL_JUSTIFY_BIT    11
`define CTL_SOFT_RESET_DISABLE_BIT      9
`define CTL_TRIG_EN_BIT    8
`define CTL_PIN_EN_BIT     7
`define CTL_TSEL_HI        6
`define CTL_TSEL_LO        2
`define CTL_REF_HI         1
`define CTL_REF_LO         0
`define CTL_WRITE_MASK     16'hBBFF

// Buffer register fields.
`define BUF_MULT_HI        1
`define BUF_MULT_LO        0
`define BUF_WRITE_MASK     16'h0003

// Reset values.
`define CONTROL_RESET      16'h0000
`define CODE_RESET         16'h0000
`define BUFFER_RESET       16'h0001

// Trigger source codes.
`define TSEL_CCP1          5'h01
`define TSEL_CCP5          5'h05
`define TSEL_EXT0          5'h08
`define TSEL_EXT1          5'h09
`define TSEL_EXT2          5'h0A
`define TSEL_TMR1          5'h0B
`define TSEL_CLC1          5'h11
`define TSEL_CLC2          5'h12
`define TSEL_CMP1          5'h18
`define TSEL_CMP2          5'h19
`define TSEL_CMP3          5'h1A
`define TSEL_ADC           5'h1B
`define TSEL_CHARGE_TIME_UNIT          5'h1C

// Full-scale divisor of the ladder.
`define LADDER_STEPS       256

`endif

// file: common/dac_ctl_pkg.sv
// Types shared by the converter channel and its bench.
// Assumes the map header sits on the include path.
package dac_ctl_pkg;
  `include "dac_ctl_map.svh"

  // Reference source choice.
  typedef enum logic [1:0] {
    REF_NONE     = 2'h0,
    REF_EXT_POS  = 2'h1,
    REF_SUPPLY   = 2'h2,
    REF_BAND_GAP = 2'h3
  } reference_e;

  // Band-gap buffer multiplier choice.
  typedef enum logic [1:0] {
    MULT_RESERVED = 2'h0,
    MULT_X1       = 2'h1,
    MULT_X2       = 2'h2,
    MULT_X4       = 2'h3
  } multiplier_e;

  // Channel power state.
  typedef enum logic [2:0] {
    ST_OFF  = 3'b001,
    ST_RUN  = 3'b010,
    ST_HOLD = 3'b100
  } channel_e;

  // Raw trigger event inputs from neighbouring peripherals.
  typedef struct packed {
    logic [4:0] capture_compare;
    logic [2:0] ext_interrupt;
    logic       timer1_sync;
    logic [1:0] logic_cell;
    logic [2:0] comparator;
    logic       adc_done;
    logic       charge_time;
  } trigger_s;

  // Controls toward the analog ladder and pad.
  typedef struct packed {
    logic        powered;
    logic [7:0]  ladder_code;
    reference_e  reference;
    multiplier_e multiplier;
    logic        pin_drive;
    logic        pin_to_port;
  } analog_s;
endpackage

// file: design/dac_control_trigger_logic.sv
// Digital control of one 8-bit converter channel with an Avalon-MM register slave.
// Assumes trigger events arrive asynchronously and that low-power mode levels come from
// the power controller on the same clock.
//
// Design decisions made here: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/100ps

module dac_control_trigger_logic (
  // Clock and resets.
  input  wire logic                  core_clk,
  input  wire logic                  reset_n,
  input  wire logic                  soft_reset,
  // Device low-power modes.
  input  wire logic                  device_idle,
  input  wire logic                  device_sleep,
  // Trigger event sources.
  input  wire dac_ctl_pkg::trigger_s trigger_in,
  // Avalon-MM register slave.
  input  wire logic [3:0]            avs_address,
  input  wire logic                  avs_read,
  input  wire logic                  avs_write,
  input  wire logic [31:0]           avs_writedata,
  input  wire logic [3:0]            avs_byteenable,
  output logic [31:0]                avs_readdata,
  output logic                       avs_waitrequest,
  output logic [1:0]                 avs_response,
  // Analog ladder and pad controls.
  output dac_ctl_pkg::analog_s       analog_out
);
  import dac_ctl_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Functions.

  // Maps a trigger source code to one event line; unused codes give a constant low.
  function automatic logic pick_trigger(input logic [4:0] sel, input trigger_s t);
    logic hit;
    hit = 1'b0;
    if (sel >= `TSEL_CCP1 && sel <= `TSEL_CCP5) begin
      hit = t.capture_compare[3'(sel - `TSEL_CCP1)];
    end else if (sel == `TSEL_EXT0) begin
      hit = t.ext_interrupt[0];
    end else if (sel == `TSEL_EXT1) begin
      hit = t.ext_interrupt[1];
    end else if (sel == `TSEL_EXT2) begin
      hit = t.ext_interrupt[2];
    end else if (sel == `TSEL_TMR1) begin
      hit = t.timer1_sync;
    end else if (sel == `TSEL_CLC1) begin
      hit = t.logic_cell[0];
    end else if (sel == `TSEL_CLC2) begin
      hit = t.logic_cell[1];
    end else if (sel == `TSEL_CMP1) begin
      hit = t.comparator[0];
    end else if (sel == `TSEL_CMP2) begin
      hit = t.comparator[1];
    end else if (sel == `TSEL_CMP3) begin
      hit = t.comparator[2];
    end else if (sel == `TSEL_ADC) begin
      hit = t.adc_done;
    end else if (sel == `TSEL_CHARGE_TIME_UNIT) begin
      hit = t.charge_time;
    end else begin
      hit = 1'b0;
    end
    return hit;
  endfunction

  // Merges bus bytes into a 16-bit register under a writable-bit mask.
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
                                          input logic [3:0] be, input logic [15:0] mask);
    logic [15:0] v;
    v = old;
    if (be[0]) begin
      v[7:0] = wd[7:0];
    end
    if (be[1]) begin
      v[15:8] = wd[15:8];
    end
    return v & mask;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Registers and bus decode.

  logic [15:0] control_q;
  logic [15:0] code_q;
  logic [15:0] buffer_q;
  logic [7:0]  ladder_q;
  logic        pending_q;
  logic        trig_meta_q;
  logic        trig_sync_q;
  logic        trig_prev_q;
  logic        soft_clear;
  logic        wr_control;
  logic        wr_code;
  logic        wr_buffer;
  logic        addr_ok;
  logic        trig_rise;
  logic [7:0]  chosen_code;
  logic [15:0] code_next;
  channel_e    state_q;
  channel_e    state_d;

  // Soft resets only clear the channel while the disable bit is clear.
  assign soft_clear = soft_reset && !control_q[`CTL_SOFT_RESET_DISABLE_BIT];

  // Every access answers in the cycle it is presented, so waitrequest never rises.
  assign avs_waitrequest = 1'b0;

  // Address decode.
  always_comb begin
    wr_control = 1'b0;
    wr_code    = 1'b0;
    wr_buffer  = 1'b0;
    addr_ok    = 1'b1;
    if (avs_address == `OFS_CONTROL) begin
      wr_control = avs_write;
    end else if (avs_address == `OFS_CODE) begin
      wr_code = avs_write;
    end else if (avs_address == `OFS_BUFFER) begin
      wr_buffer = avs_write;
    end else if (avs_address == `OFS_STATUS) begin
      addr_ok = 1'b1;
    end else begin
      addr_ok = 1'b0;
    end
  end

  // Read data and response are combinational from the address, so the data stand at the
  // very edge where waitrequest is sampled low; no read side effects exist.
  always_comb begin
    avs_readdata = 32'h0000_0000;
    avs_response = addr_ok ? 2'h0 : 2'h2;
    if (avs_address == `OFS_CONTROL) begin
      avs_readdata = {16'h0000, control_q};
    end else if (avs_address == `OFS_CODE) begin
      avs_readdata = {16'h0000, code_q};
    end else if (avs_address == `OFS_BUFFER) begin
      avs_readdata = {16'h0000, buffer_q};
    end else if (avs_address == `OFS_STATUS) begin
      avs_readdata = {16'h0000, ladder_q, pending_q, 4'h0, state_q};
    end else begin
      avs_readdata = 32'h0000_0000;
    end
  end

  // Control register; unimplemented bits 14 and 10 are masked off on write.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      control_q <= `CONTROL_RESET;
    end else if (soft_clear) begin
      control_q <= `CONTROL_RESET;
    end else if (wr_control) begin
      control_q <= merge16(control_q, avs_writedata, avs_byteenable, `CTL_WRITE_MASK);
    end
  end

  // Code register holds the full word; justification picks the byte used.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      code_q <= `CODE_RESET;
    end else if (soft_clear) begin
      code_q <= `CODE_RESET;
    end else if (wr_code) begin
      code_q <= merge16(code_q, avs_writedata, avs_byteenable, 16'hFFFF);
    end
  end

  // Buffer register belongs to the shared reference and returns to its reset value 1 on every device reset.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      buffer_q <= `BUFFER_RESET;
    end else if (soft_reset) begin
      buffer_q <= `BUFFER_RESET;
    end else if (wr_buffer) begin
      buffer_q <= merge16(buffer_q, avs_writedata, avs_byteenable, `BUF_WRITE_MASK);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Channel state.

  // Idle stop and sleep power-down override the enable; sleep with run set holds the code.
  always_comb begin
    state_d = ST_OFF;
    if (!control_q[`CTL_ENABLE_BIT]) begin
      state_d = ST_OFF;
    end else if (device_sleep) begin
      state_d = control_q[`CTL_SLEEP_RUN_BIT] ? ST_HOLD : ST_OFF;
    end else if (device_idle && control_q[`CTL_IDLE_STOP_BIT]) begin
      state_d = ST_OFF;
    end else begin
      state_d = ST_RUN;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= ST_OFF;
    end else begin
      case (state_q)
        ST_OFF:  state_q <= state_d;
        ST_RUN:  state_q <= state_d;
        ST_HOLD: state_q <= state_d;
        default: state_q <= ST_OFF;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Trigger path.

  // Two-stage synchroniser on the selected event; the mux glitches on select changes, which
  // can cost one spurious edge, so software should change the source with triggering off.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      trig_meta_q <= 1'b0;
      trig_sync_q <= 1'b0;
      trig_prev_q <= 1'b0;
    end else begin
      trig_meta_q <= pick_trigger(control_q[`CTL_TSEL_HI:`CTL_TSEL_LO], trigger_in);
      trig_sync_q <= trig_meta_q;
      trig_prev_q <= trig_sync_q;
    end
  end

  assign trig_rise = trig_sync_q && !trig_prev_q;

  // Code word as it will stand after the current write; feeds the immediate update path.
  assign code_next = merge16(code_q, avs_writedata, avs_byteenable, 16'hFFFF);

  // Byte presented to the ladder.
  assign chosen_code = control_q[`CTL_JUSTIFY_BIT] ? code_q[15:8] : code_q[7:0];

  // Edge seen while running is flagged, then the ladder loads on the next cycle.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      pending_q <= 1'b0;
    end else begin
      pending_q <= trig_rise && control_q[`CTL_TRIG_EN_BIT] && (state_q == ST_RUN);
    end
  end

  // Ladder input register: immediate on write, or on the flagged trigger edge.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      ladder_q <= 8'h00;
    end else if (soft_clear) begin
      ladder_q <= 8'h00;
    end else if (state_q != ST_RUN) begin
      ladder_q <= ladder_q;
    end else if (control_q[`CTL_TRIG_EN_BIT]) begin
      if (pending_q) begin
        ladder_q <= chosen_code;
      end
    end else if (wr_code) begin
      ladder_q <= control_q[`CTL_JUSTIFY_BIT] ? code_next[15:8] : code_next[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Analog controls.

  // The ladder forms reference * code / 256; no reference means no conversion at all.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      analog_out <= '{powered: 1'b0, ladder_code: 8'h00, reference: REF_NONE,
                      multiplier: MULT_X1, pin_drive: 1'b0, pin_to_port: 1'b1};
    end else begin
      analog_out.powered     <= (state_q != ST_OFF) &&
                                (control_q[`CTL_REF_HI:`CTL_REF_LO] != REF_NONE);
      analog_out.ladder_code <= ladder_q;
      analog_out.reference   <= reference_e'(control_q[`CTL_REF_HI:`CTL_REF_LO]);
      analog_out.multiplier  <= multiplier_e'(buffer_q[`BUF_MULT_HI:`BUF_MULT_LO]);
      analog_out.pin_drive   <= (state_q != ST_OFF) && control_q[`CTL_PIN_EN_BIT];
      analog_out.pin_to_port <= (state_q == ST_OFF);
    end
  end

endmodule // dac_control_trigger_logic

// file: tb/dac_control_trigger_logic_bench.sv
// Self-checking bench for the converter channel: registers, triggers, power modes, resets.
// Assumes the checker is bound to the channel and runs on one 100 MHz clock.
`timescale 1ns/100ps
module dac_control_trigger_logic_bench;
  import dac_ctl_pkg::*;
  logic        core_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        soft_reset = 1'b0;
  logic        device_idle = 1'b0;
  logic        device_sleep = 1'b0;
  trigger_s    trigger_in = '0;
  logic [3:0]  avs_address = 4'h0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0]  avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [1:0]  avs_response;
  analog_s     analog_out;
  int          err_total = 0;
  int          n_compared = 0;
  int          b;
  logic [31:0] rd;
  logic [1:0]  rsp;
  logic [7:0]  last;
  logic [15:0] d;
  trigger_s    x;
  always #5 core_clk = ~core_clk;
  dac_control_trigger_logic i_dac_control_trigger_logic (.core_clk, .reset_n, .soft_reset,
    .device_idle, .device_sleep, .trigger_in, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .avs_response,
    .analog_out);
  ////////////////////////////////////////////////////////////
  // Comparison, bus cycle and timing helpers.
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // The request is held until waitrequest is seen low or 50 cycles pass, so answers within 50 cycles are safe.
  task automatic bus(input logic wr, input logic [3:0] a, input logic [15:0] wd);
    int n;
    n = 0;
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= {16'h0000, wd};
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge core_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    rd = avs_readdata;
    rsp = avs_response;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  // Waiting past the edge by 1 ns lets registered outputs settle before sampling.
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic srst();
    @(posedge core_clk);
    soft_reset <= 1'b1;
    @(posedge core_clk);
    soft_reset <= 1'b0;
  endtask
  // Trigger bit within the packed event bundle, or -1 when no source is connected.
  function automatic int src_bit(input logic [4:0] c);
    if (c >= 5'h01 && c <= 5'h05) return 10 + c;
    if (c >= 5'h08 && c <= 5'h0A) return c;
    if (c == 5'h0B) return 7;
    if (c == 5'h11 || c == 5'h12) return c - 12;
    if (c >= 5'h18 && c <= 5'h1A) return c - 22;
    if (c == 5'h1B) return 1;
    if (c == 5'h1C) return 0;
    return -1;
  endfunction
  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    #200000;
    err_total++;
    final_report();
  end
  // Main sequence.
  initial begin
    rd = $urandom(95756);
    repeat (3) @(posedge core_clk);
    reset_n <= 1'b1;
    bus(0, 4'h0, 16'h0000);
    chk(rd, 32'h0);
    bus(0, 4'h8, 16'h0000);
    chk(rd, 32'h1);
    bus(0, 4'h2, 16'h0000);
    chk(rsp, 2'h2);
    chk(analog_out.pin_to_port, 1'b1);
    $display("test reset done");
    repeat (8) begin
      d = $urandom;
      bus(1, 4'h0, d);
      bus(0, 4'h0, 16'h0000);
      chk(rd, d & 16'hBBFF);
      bus(1, 4'h8, d);
      bus(0, 4'h8, 16'h0000);
      chk(rd, d & 16'h0003);
      cyc(3);
      chk(analog_out.multiplier, d[1:0]);
    end
    bus(1, 4'h8, 16'h0001);
    $display("test registers done");
    for (int j = 0; j < 2; j++) begin
      for (int r = 1; r < 4; r++) begin
        bus(1, 4'h0, 16'h8000 | (j << 11) | r);
        d = (r == 1) ? 16'hFF00 : 16'($urandom);
        bus(1, 4'h4, d);
        cyc(3);
        last = j ? d[15:8] : d[7:0];
        chk(analog_out.ladder_code, last);
        chk(analog_out.reference, r);
        chk(analog_out.powered, 1'b1);
      end
    end
    bus(1, 4'h0, 16'h8000);
    cyc(3);
    chk(analog_out.powered, 1'b0);
    $display("test immediate done");
    for (int c = 0; c < 32; c++) begin
      bus(1, 4'h0, 16'h8102 | (c << 2));
      d = $urandom;
      bus(1, 4'h4, d);
      cyc(3);
      chk(analog_out.ladder_code, last);
      b = src_bit(c);
      x = '1;
      if (b >= 0) x[b] = 1'b0;
      @(posedge core_clk);
      trigger_in <= x;
      cyc(6);
      chk(analog_out.ladder_code, last);
      if (b >= 0) begin
        @(posedge core_clk);
        trigger_in <= '1;
        cyc(4);
        chk(analog_out.ladder_code, last);
        last = d[7:0];
        cyc(1);
      end
      chk(analog_out.ladder_code, last);
      @(posedge core_clk);
      trigger_in <= '0;
      cyc(3);
    end
    $display("test triggers done");
    bus(1, 4'h0, 16'h8082);
    bus(1, 4'h4, 16'h0011);
    @(posedge core_clk);
    device_idle <= 1'b1;
    cyc(3);
    bus(1, 4'h4, 16'h0022);
    cyc(3);
    chk(analog_out.ladder_code, 8'h22);
    chk(analog_out.pin_drive, 1'b1);
    @(posedge core_clk);
    device_idle <= 1'b0;
    bus(1, 4'h0, 16'hA082);
    @(posedge core_clk);
    device_idle <= 1'b1;
    cyc(3);
    bus(1, 4'h4, 16'h0033);
    cyc(3);
    chk(analog_out.ladder_code, 8'h22);
    @(posedge core_clk);
    device_idle <= 1'b0;
    bus(1, 4'h0, 16'h9082);
    bus(1, 4'h4, 16'h0044);
    @(posedge core_clk);
    device_sleep <= 1'b1;
    cyc(4);
    chk(analog_out.ladder_code, 8'h44);
    chk(analog_out.pin_drive, 1'b1);
    @(posedge core_clk);
    device_sleep <= 1'b0;
    bus(1, 4'h0, 16'h8082);
    @(posedge core_clk);
    device_sleep <= 1'b1;
    cyc(4);
    chk({analog_out.powered, analog_out.pin_drive, analog_out.pin_to_port}, 3'b001);
    @(posedge core_clk);
    device_sleep <= 1'b0;
    bus(1, 4'h0, 16'h8002);
    cyc(3);
    chk(analog_out.pin_drive, 1'b0);
    $display("test power modes done");
    bus(1, 4'h0, 16'h8282);
    bus(1, 4'h4, 16'h0055);
    bus(1, 4'h8, 16'h0003);
    srst();
    bus(0, 4'h0, 16'h0000);
    chk(rd, 32'h8282);
    bus(0, 4'h4, 16'h0000);
    chk(rd, 32'h0055);
    bus(0, 4'h8, 16'h0000);
    chk(rd, 32'h1);
    chk(analog_out.ladder_code, 8'h55);
    bus(1, 4'h0, 16'h8082);
    srst();
    bus(0, 4'h0, 16'h0000);
    chk(rd, 32'h0);
    bus(0, 4'h4, 16'h0000);
    chk(rd, 32'h0);
    bus(1, 4'h0, 16'h0002);
    bus(1, 4'h4, 16'h0066);
    cyc(3);
    chk({analog_out.powered, analog_out.ladder_code}, 9'h000);
    bus(0, 4'hC, 16'h0000);
    chk(rd, 32'h0000_0001);
    chk(rsp, 2'h0);
    $display("test soft reset done");
    final_report();
  end
endmodule // dac_control_trigger_logic_bench

// file: tb/dac_ctl_properties.sv
// Checker for the converter channel: bus answers, readback and pad controls.
// Assumes a bind to the channel; bus writes always carry all byte lanes.
`timescale 1ns/100ps
module dac_ctl_properties (
  // Clock and resets.
  input wire logic                  core_clk,
  input wire logic                  reset_n,
  input wire logic                  soft_reset,
  // Low-power modes.
  input wire logic                  device_sleep,
  // Register bus.
  input wire logic [3:0]            avs_address,
  input wire logic                  avs_read,
  input wire logic                  avs_write,
  input wire logic [31:0]           avs_writedata,
  input wire logic [31:0]           avs_readdata,
  input wire logic                  avs_waitrequest,
  input wire logic [1:0]            avs_response,
  // Pad controls.
  input wire dac_ctl_pkg::analog_s  analog_out
);
  import dac_ctl_pkg::*;
  logic [15:0] ctl_q;
  logic        mapped;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  ////////////////////////////////////////////////////////////
  // Shadow of the control register; byte lanes are ignored, so partial writes are not modelled.
  assign mapped = (avs_address[1:0] == 2'h0);
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctl_q <= 16'h0000;
    end else if (soft_reset && !ctl_q[9]) begin
      ctl_q <= 16'h0000;
    end else if (avs_write && avs_address == 4'h0) begin
      ctl_q <= avs_writedata[15:0] & 16'hBBFF;
    end
  end
  ////////////////////////////////////////////////////////////
  wait_low_a: assert property (avs_waitrequest == 1'b0) else $error("wait state seen");
  resp_code_a: assert property ((avs_read || avs_write) |->
    avs_response == (mapped ? 2'h0 : 2'h2)) else $error("bad response code");
  upper_zero_a: assert property (avs_read |-> avs_readdata[31:16] == 16'h0000)
    else $error("upper read half not zero");
  buf_unused_a: assert property (avs_read && avs_address == 4'h8 |->
    avs_readdata[15:2] == 14'h0000) else $error("buffer unused bits set");
  ctl_read_a: assert property (avs_read && avs_address == 4'h0 |->
    avs_readdata[15:0] == ctl_q) else $error("control readback wrong");
  no_ref_off_a: assert property (analog_out.reference == REF_NONE |->
    !analog_out.powered) else $error("powered without reference");
  pin_off_a: assert property (!ctl_q[7] [*3] |-> !analog_out.pin_drive)
    else $error("pin driven while disabled");
  disabled_off_a: assert property (!ctl_q[15] [*3] |-> !analog_out.powered)
    else $error("powered while disabled");
  sleep_off_a: assert property ((device_sleep && !ctl_q[12]) [*3] |->
    !analog_out.powered && analog_out.pin_to_port) else $error("sleep not powered down");
  sleep_hold_a: assert property ((device_sleep && ctl_q[12] && ctl_q[15]) [*3] |->
    $stable(analog_out.ladder_code)) else $error("ladder moved in sleep");
endmodule // dac_ctl_properties

bind dac_control_trigger_logic dac_ctl_properties i_dac_ctl_properties (.core_clk, .reset_n,
  .soft_reset, .device_sleep, .avs_address, .avs_read, .avs_write, .avs_writedata,
  .avs_readdata, .avs_waitrequest, .avs_response, .analog_out);
